// ---- verilog/adc_clk_pkg.sv ----
// Purpose: Shared constants and types for the sample-clock divider and
//          power-mode controller.
// Assumes: Register indices times four give the APB byte address.
// Notes:   Field positions and reset values live here only.
package adc_clk_pkg;

    // Register indices; the APB byte address is four times the index.
    localparam logic [11:0] IDX_SOFT_PD    = 12'h03f;
    localparam logic [11:0] IDX_PIN_FUNC   = 12'h040;
    localparam logic [11:0] IDX_CLK_DIV    = 12'h108;
    localparam logic [11:0] IDX_DIV_PRESET = 12'h109;
    localparam logic [11:0] IDX_STATUS     = 12'h10a;
    localparam logic [11:0] IDX_DCS        = 12'h11c;
    localparam logic [11:0] IDX_LINK_CTRL  = 12'h571;

    // Field positions.
    localparam int DIV_SEL_LSB   = 0;
    localparam int PRESET_LSB    = 0;
    localparam int DCS_EN_BIT    = 0;
    localparam int SOFT_PD_BIT   = 0;
    localparam int PIN_STBY_BIT  = 0;
    localparam int K_SEL_BIT     = 7;
    localparam int ST_SEL_LSB    = 0;
    localparam int ST_MODE_LSB   = 2;
    localparam int ST_LINK_BIT   = 4;
    localparam int ST_CNT_LSB    = 5;

    // Reset values.
    localparam logic [1:0] RST_DIV_SEL  = 2'h0;
    localparam logic [2:0] RST_PRESET   = 3'h0;
    localparam logic       RST_DCS_EN   = 1'h0;
    localparam logic       RST_SOFT_PD  = 1'h0;
    localparam logic       RST_PIN_STBY = 1'h0;
    localparam logic       RST_K_SEL    = 1'h0;

    // Widths and link coding.
    localparam int         SAMPLE_W   = 16;
    localparam logic [7:0] K_CHAR     = 8'hbc;
    localparam int         PERIOD_W   = 8;

    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_STANDBY,
        PM_POWER_DOWN
    } power_mode_t;

    typedef struct packed {
        logic                valid;
        logic [1:0]          ctrl_k;
        logic [SAMPLE_W-1:0] data;
    } link_word_t;

endpackage : adc_clk_pkg

// ---- verilog/duty_regen.sv ----
// Purpose: Regenerates a fifty-percent clock from the divided rising edges.
// Assumes: Input rising edges arrive as one-cycle pulses on pclk.
// Notes:   The high time is half the measured input period times the ratio.
`timescale 1ns/1ps
module duty_regen #(
    parameter int CNT_W = adc_clk_pkg::PERIOD_W
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Edge pulses and ratio.
    input  wire logic             in_rise,
    input  wire logic             div_rise,
    input  wire logic [1:0]       ratio_sel,
    // Regenerated level.
    output logic                  high_ff
);
    logic [CNT_W-1:0] per_cnt_ff;
    logic [CNT_W-1:0] period_ff;
    logic [CNT_W-1:0] run_ff;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] nxt_per_cnt;

    // Half of the input period scaled by the ratio.
    assign half = CNT_W'((period_ff << ratio_sel) >> 1);
    assign nxt_per_cnt = in_rise ? CNT_W'(1) : per_cnt_ff + CNT_W'(1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            per_cnt_ff <= '0;
            period_ff  <= '0;
        end
        else
        begin
            per_cnt_ff <= nxt_per_cnt;
            if (in_rise)
                period_ff <= per_cnt_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_ff <= 1'b0;
            run_ff  <= '0;
        end
        else if (div_rise)
        begin
            high_ff <= 1'b1;
            run_ff  <= CNT_W'(1);
        end
        else
        begin
            run_ff <= run_ff + CNT_W'(1);
            if (run_ff >= half)
                high_ff <= 1'b0;
        end
    end

    property p_high_len;
        @(posedge pclk) disable iff (!presetn)
        (high_ff && !div_rise && run_ff < half) |=> high_ff;
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("Regenerated clock fell before half period.");

endmodule : duty_regen

// ---- verilog/adc_clk_ctrl.sv ----
// Purpose: Clock divider, stabiliser and power modes behind APB.
// Assumes: clk_in, sysref and power_mode_pin are synchronous to pclk.
// Notes:   The rules below are listed here only; the logic carries no tags.
// Operation
// - Divide input clock by one, two, four, eight.
// - Valid sync event presets divider to programmed state.
// - Divided clock to core has fifty-percent duty; here divide-by-one keeps the clk_in duty unless the stabiliser is on.
// - Register bit enables the duty-cycle stabiliser.
// - Pin defaults to power-down, standby by configuration.
// - Power-mode pin is active high.
// - Power-down drops the serial link.
// - Power-down also selectable from two registers; here only the soft power-down register.
// - Standby keeps link up, sends zero samples.
// - Config bit sends control characters in standby.
// - Samples taken on divided clock rising edge.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module adc_clk_ctrl (
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Clock, sync and power pins.
    input  wire logic                  clk_in,
    input  wire logic                  sysref,
    input  wire logic                  power_mode_pin,
    // Converter side.
    input  wire logic [adc_clk_pkg::SAMPLE_W-1:0] adc_sample,
    output logic                       sample_clk,
    output logic                       sample_take,
    // Serial link side.
    output logic                       link_up,
    output adc_clk_pkg::link_word_t    link_word
);
    // Registers.
    logic [1:0]               div_sel_ff;
    logic [2:0]               preset_ff;
    logic                     dcs_en_ff;
    logic                     soft_pd_ff;
    logic                     pin_stby_ff;
    logic                     k_sel_ff;
    logic                     pready_ff;
    logic [31:0]              prdata_ff;
    logic                     pslverr_ff;
    // Divider, power-mode and link state.
    logic                     clk_in_q_ff;
    logic                     sysref_q_ff;
    logic [2:0]               cnt_ff;
    logic [1:0]               act_sel_ff;
    logic                     div_q_ff;
    logic                     sample_clk_ff;
    logic                     sample_take_ff;
    adc_clk_pkg::power_mode_t mode_ff;
    logic                     link_up_ff;
    adc_clk_pkg::link_word_t  link_word_ff;
    // Combinational terms.
    logic [11:0]              idx;
    logic                     setup;
    logic                     wr_en;
    logic                     hit;
    logic [31:0]              rd_mux;
    logic [31:0]              status_word;
    logic                     in_rise;
    logic                     sysref_rise;
    logic                     pd;
    logic                     div_reset;
    logic                     div_lvl;
    logic                     div_rise;
    logic                     regen_high;
    adc_clk_pkg::power_mode_t nxt_mode;
    logic [2:0]               nxt_cnt;
    adc_clk_pkg::link_word_t  nxt_link_word;

    // Register decode.
    assign idx   = paddr[13:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign hit   = (idx == adc_clk_pkg::IDX_SOFT_PD)
                || (idx == adc_clk_pkg::IDX_PIN_FUNC)
                || (idx == adc_clk_pkg::IDX_CLK_DIV)
                || (idx == adc_clk_pkg::IDX_DIV_PRESET)
                || (idx == adc_clk_pkg::IDX_STATUS)
                || (idx == adc_clk_pkg::IDX_DCS)
                || (idx == adc_clk_pkg::IDX_LINK_CTRL);

    assign status_word =
        (32'(act_sel_ff) << adc_clk_pkg::ST_SEL_LSB)
      | (32'(mode_ff)    << adc_clk_pkg::ST_MODE_LSB)
      | (32'(link_up_ff) << adc_clk_pkg::ST_LINK_BIT)
      | (32'(cnt_ff)     << adc_clk_pkg::ST_CNT_LSB);

    assign rd_mux =
        (idx == adc_clk_pkg::IDX_SOFT_PD)
            ? 32'(soft_pd_ff) << adc_clk_pkg::SOFT_PD_BIT
      : (idx == adc_clk_pkg::IDX_PIN_FUNC)
            ? 32'(pin_stby_ff) << adc_clk_pkg::PIN_STBY_BIT
      : (idx == adc_clk_pkg::IDX_CLK_DIV)
            ? 32'(div_sel_ff) << adc_clk_pkg::DIV_SEL_LSB
      : (idx == adc_clk_pkg::IDX_DIV_PRESET)
            ? 32'(preset_ff) << adc_clk_pkg::PRESET_LSB
      : (idx == adc_clk_pkg::IDX_STATUS)
            ? status_word
      : (idx == adc_clk_pkg::IDX_DCS)
            ? 32'(dcs_en_ff) << adc_clk_pkg::DCS_EN_BIT
      : (idx == adc_clk_pkg::IDX_LINK_CTRL)
            ? 32'(k_sel_ff) << adc_clk_pkg::K_SEL_BIT
      : 32'h0000_0000;

    // Read data and error are set up in the setup cycle, so the access
    // phase answers at once with no wait states.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= 1'b1;
            if (setup)
            begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_ff <= !hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_sel_ff  <= adc_clk_pkg::RST_DIV_SEL;
            preset_ff   <= adc_clk_pkg::RST_PRESET;
            dcs_en_ff   <= adc_clk_pkg::RST_DCS_EN;
            soft_pd_ff  <= adc_clk_pkg::RST_SOFT_PD;
            pin_stby_ff <= adc_clk_pkg::RST_PIN_STBY;
            k_sel_ff    <= adc_clk_pkg::RST_K_SEL;
        end
        else if (wr_en)
        begin
            if (idx == adc_clk_pkg::IDX_CLK_DIV)
                div_sel_ff <= pwdata[adc_clk_pkg::DIV_SEL_LSB +: 2];
            if (idx == adc_clk_pkg::IDX_DIV_PRESET)
                preset_ff <= pwdata[adc_clk_pkg::PRESET_LSB +: 3];
            if (idx == adc_clk_pkg::IDX_DCS)
                dcs_en_ff <= pwdata[adc_clk_pkg::DCS_EN_BIT];
            if (idx == adc_clk_pkg::IDX_SOFT_PD)
                soft_pd_ff <= pwdata[adc_clk_pkg::SOFT_PD_BIT];
            if (idx == adc_clk_pkg::IDX_PIN_FUNC)
                pin_stby_ff <= pwdata[adc_clk_pkg::PIN_STBY_BIT];
            if (idx == adc_clk_pkg::IDX_LINK_CTRL)
                k_sel_ff <= pwdata[adc_clk_pkg::K_SEL_BIT];
        end
    end

    // Power mode: the pin selects power-down or standby by its function
    // bit; the register power-down overrides everything.
    assign nxt_mode =
        soft_pd_ff                       ? adc_clk_pkg::PM_POWER_DOWN
      : (power_mode_pin && !pin_stby_ff) ? adc_clk_pkg::PM_POWER_DOWN
      : power_mode_pin                   ? adc_clk_pkg::PM_STANDBY
      : adc_clk_pkg::PM_ACTIVE;

    assign pd = (mode_ff == adc_clk_pkg::PM_POWER_DOWN);

    // Divider: sync event or power-down loads the preset and the ratio.
    assign in_rise     = clk_in && !clk_in_q_ff;
    assign sysref_rise = sysref && !sysref_q_ff;
    assign div_reset   = pd || sysref_rise;
    assign nxt_cnt     = in_rise ? cnt_ff + 3'h1 : cnt_ff;
    assign div_lvl     = (act_sel_ff == 2'h0) ? clk_in
                       : cnt_ff[act_sel_ff - 2'h1];
    assign div_rise    = div_lvl && !div_q_ff && !pd;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_in_q_ff <= 1'b0;
            sysref_q_ff <= 1'b0;
            div_q_ff    <= 1'b0;
            mode_ff     <= adc_clk_pkg::PM_ACTIVE;
        end
        else
        begin
            clk_in_q_ff <= clk_in;
            sysref_q_ff <= sysref;
            div_q_ff    <= div_lvl;
            mode_ff     <= nxt_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff     <= adc_clk_pkg::RST_PRESET;
            act_sel_ff <= adc_clk_pkg::RST_DIV_SEL;
        end
        else if (div_reset)
        begin
            cnt_ff     <= preset_ff;
            act_sel_ff <= div_sel_ff;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    duty_regen #(
        .CNT_W     (adc_clk_pkg::PERIOD_W)
    ) u_regen (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_rise   (in_rise),
        .div_rise  (div_rise),
        .ratio_sel (act_sel_ff),
        .high_ff   (regen_high)
    );

    // Stabiliser on: regenerated half-period clock; off: the divider.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_clk_ff  <= 1'b0;
            sample_take_ff <= 1'b0;
        end
        else
        begin
            sample_clk_ff  <= !pd && (dcs_en_ff ? regen_high
                                                : div_lvl);
            sample_take_ff <= div_rise;
        end
    end

    // Link word: real samples when active, zeros or control characters
    // in standby, nothing in power-down.
    always_comb
    begin
        nxt_link_word = '0;
        if (sample_take_ff && !pd)
        begin
            nxt_link_word.valid = 1'b1;
            if (mode_ff == adc_clk_pkg::PM_STANDBY && k_sel_ff)
            begin
                nxt_link_word.ctrl_k = 2'h3;
                nxt_link_word.data = {adc_clk_pkg::K_CHAR,
                                      adc_clk_pkg::K_CHAR};
            end
            else if (mode_ff == adc_clk_pkg::PM_STANDBY)
                nxt_link_word.data = '0;
            else
                nxt_link_word.data = adc_sample;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_up_ff   <= 1'b0;
            link_word_ff <= '0;
        end
        else
        begin
            link_up_ff   <= !pd;
            link_word_ff <= nxt_link_word;
        end
    end

    assign pready      = pready_ff;
    assign prdata      = prdata_ff;
    assign pslverr     = pslverr_ff;
    assign sample_clk  = sample_clk_ff;
    assign sample_take = sample_take_ff;
    assign link_up     = link_up_ff;
    assign link_word   = link_word_ff;

    property p_sync_preset;
        @(posedge pclk) disable iff (!presetn)
        (sysref_rise && !pd) |=> (cnt_ff == $past(preset_ff))
                                 && (act_sel_ff == $past(div_sel_ff));
    endproperty
    a_sync_preset: assert property (p_sync_preset)
        else $error("Divider not preset on sync event.");

    property p_ratio_hold;
        @(posedge pclk) disable iff (!presetn)
        (!div_reset) |=> $stable(act_sel_ff);
    endproperty
    a_ratio_hold: assert property (p_ratio_hold)
        else $error("Ratio changed without divider reset.");

    property p_count;
        @(posedge pclk) disable iff (!presetn)
        (in_rise && !div_reset) |=> cnt_ff == $past(cnt_ff) + 3'h1;
    endproperty
    a_count: assert property (p_count)
        else $error("Divider did not count an input edge.");

    property p_take;
        @(posedge pclk) disable iff (!presetn)
        div_rise |=> sample_take_ff ##1 !sample_take_ff || div_rise;
    endproperty
    a_take: assert property (p_take)
        else $error("Sample not taken on divided rising edge.");

    property p_pd_link;
        @(posedge pclk) disable iff (!presetn)
        pd |=> !link_up_ff && !link_word_ff.valid;
    endproperty
    a_pd_link: assert property (p_pd_link)
        else $error("Link alive during power-down.");

    property p_pin_pd;
        @(posedge pclk) disable iff (!presetn)
        (power_mode_pin && !pin_stby_ff) |=>
            mode_ff == adc_clk_pkg::PM_POWER_DOWN ##1 !link_up_ff;
    endproperty
    a_pin_pd: assert property (p_pin_pd)
        else $error("Pin did not select power-down.");

    property p_soft_pd;
        @(posedge pclk) disable iff (!presetn)
        soft_pd_ff |=> mode_ff == adc_clk_pkg::PM_POWER_DOWN;
    endproperty
    a_soft_pd: assert property (p_soft_pd)
        else $error("Register power-down ignored.");

    property p_stby_zero;
        @(posedge pclk) disable iff (!presetn)
        (sample_take_ff && mode_ff == adc_clk_pkg::PM_STANDBY
         && !k_sel_ff) |=> link_word_ff.valid && link_word_ff.data == '0
                           && link_up_ff;
    endproperty
    a_stby_zero: assert property (p_stby_zero)
        else $error("Standby sample not zero.");

    property p_stby_k;
        @(posedge pclk) disable iff (!presetn)
        (sample_take_ff && mode_ff == adc_clk_pkg::PM_STANDBY
         && k_sel_ff) |=> link_word_ff.ctrl_k == 2'h3;
    endproperty
    a_stby_k: assert property (p_stby_k)
        else $error("Standby did not send control characters.");

    c_sync: cover property (@(posedge pclk) disable iff (!presetn)
        sysref_rise && !pd);
    c_stby_k: cover property (@(posedge pclk) disable iff (!presetn)
        link_word_ff.valid && link_word_ff.ctrl_k == 2'h3);
    c_pd: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(link_up_ff));

endmodule : adc_clk_ctrl

// ---- tb/clk_link_model.sv ----
// Purpose: Far side of the block: a gated clock source and a link receiver.
// Assumes: Clock high and low times are given in pclk cycles, each >= 1.
// Notes:   The clock stands still low whenever run is low.
`timescale 1ns/1ps
module clk_link_model (
    // Clock and reset.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // Clock source control.
    input  wire logic                    run,
    input  wire logic [3:0]              hi,
    input  wire logic [3:0]              lo,
    output logic                         clk_in,
    // Link receiver.
    input  wire logic                    link_up,
    input  wire adc_clk_pkg::link_word_t link_word,
    output int                           n_words,
    output adc_clk_pkg::link_word_t      last_word
);
    logic [3:0] cnt_ff;

    // The bench sets the ratio before raising run.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 4'h0;
            clk_in <= 1'b0;
        end
        else if (!run)
        begin
            cnt_ff <= 4'h0;
            clk_in <= 1'b0;
        end
        else if (cnt_ff == (clk_in ? hi : lo) - 4'h1)
        begin
            cnt_ff <= 4'h0;
            clk_in <= !clk_in;
        end
        else
            cnt_ff <= cnt_ff + 4'h1;
    end

    // Words count only while the link is held up.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_words   <= 0;
            last_word <= '0;
        end
        else if (link_up && link_word.valid)
        begin
            n_words   <= n_words + 1;
            last_word <= link_word;
        end
    end
endmodule : clk_link_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the divider and power-mode block.
// Assumes: Zero-wait APB slave; all pins synchronous to pclk.
// Notes:   Random samples come from a fixed-seed xorshift.
`timescale 1ns/1ps
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        clk_in;
    logic        sysref = 1'b0;
    logic        power_mode_pin = 1'b0;
    logic [15:0] adc_sample = 16'h0;
    logic        sample_clk;
    logic        sample_take;
    logic        link_up;
    logic        run = 1'b0;
    logic [3:0]  hi = 4'h2;
    logic [3:0]  lo = 4'h2;
    int          n_words;
    int          n_errors = 0;
    int          compares = 0;
    logic [31:0] rng = 32'h6a690759;
    logic [31:0] rd;
    logic        er;
    int          h;
    int          l;
    adc_clk_pkg::link_word_t link_word;
    adc_clk_pkg::link_word_t last_word;

    always #2 pclk = !pclk;

    adc_clk_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .clk_in(clk_in), .sysref(sysref), .power_mode_pin(power_mode_pin),
        .adc_sample(adc_sample), .sample_clk(sample_clk),
        .sample_take(sample_take), .link_up(link_up),
        .link_word(link_word));

    clk_link_model far_end (.pclk(pclk), .presetn(presetn), .run(run),
        .hi(hi), .lo(lo), .clk_in(clk_in), .link_up(link_up),
        .link_word(link_word), .n_words(n_words), .last_word(last_word));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [31:0] status(input logic [1:0] r,
        input logic [1:0] m, input logic up, input logic [2:0] c);
        return {24'h0, c, up, m, r};
    endfunction : status

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] idx,
        input logic [31:0] d);
        int t;
        t = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic sync();
        sysref <= 1'b1;
        repeat (3) @(posedge pclk);
        sysref <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : sync

    task automatic gap(output int n);
        int t;
        t = 0;
        while (sample_take !== 1'b1 && t < 500)
        begin
            @(posedge pclk);
            t++;
        end
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (sample_take !== 1'b1 && n < 500);
    endtask : gap

    task automatic duty(output int nh, output int nl);
        int t;
        t = 0;
        while (sample_clk !== 1'b0 && t < 500)
        begin
            @(posedge pclk);
            t++;
        end
        while (sample_clk !== 1'b1 && t < 500)
        begin
            @(posedge pclk);
            t++;
        end
        nh = 0;
        nl = 0;
        while (sample_clk === 1'b1 && nh < 500)
        begin
            @(posedge pclk);
            nh++;
        end
        while (sample_clk === 1'b0 && nl < 500)
        begin
            @(posedge pclk);
            nl++;
        end
    endtask : duty

    task automatic words(input int n);
        int c;
        int t;
        c = n_words;
        t = 0;
        while (n_words < c + n && t < 500)
        begin
            @(posedge pclk);
            t++;
        end
        chk("words", 32'h1, {31'h0, t < 500});
    endtask : words

    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        logic [11:0] ix [6];
        logic [31:0] mk [6];
        logic [15:0] smp;
        ix = '{adc_clk_pkg::IDX_SOFT_PD, adc_clk_pkg::IDX_PIN_FUNC,
               adc_clk_pkg::IDX_CLK_DIV, adc_clk_pkg::IDX_DIV_PRESET,
               adc_clk_pkg::IDX_DCS, adc_clk_pkg::IDX_LINK_CTRL};
        mk = '{32'h1, 32'h1, 32'h3, 32'h7, 32'h1, 32'h80};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ix[i], 32'h0);
            chk("reset value", 32'h0, rd);
            rng = xs(rng);
            apb(1'b1, ix[i], rng);
            apb(1'b0, ix[i], 32'h0);
            chk("readback", rng & mk[i], rd & mk[i]);
            apb(1'b1, ix[i], 32'h0);
        end
        apb(1'b0, adc_clk_pkg::IDX_STATUS, 32'h0);
        chk("status", status(2'h0, 2'h0, 1'b1, 3'h0), rd);
        apb(1'b0, 12'h001, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        $display("register test done");
        apb(1'b1, adc_clk_pkg::IDX_CLK_DIV, 32'h2);
        apb(1'b1, adc_clk_pkg::IDX_DIV_PRESET, 32'h5);
        apb(1'b0, adc_clk_pkg::IDX_STATUS, 32'h0);
        chk("ratio held", 32'h0, rd & 32'h3);
        sync();
        apb(1'b0, adc_clk_pkg::IDX_STATUS, 32'h0);
        chk("preset", status(2'h2, 2'h0, 1'b1, 3'h5), rd);
        apb(1'b1, adc_clk_pkg::IDX_DIV_PRESET, 32'h0);
        $display("preset test done");
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, adc_clk_pkg::IDX_CLK_DIV, s);
            sync();
            run <= 1'b1;
            gap(h);
            gap(h);
            chk("take gap", 4 << s, h);
            rng = xs(rng);
            smp = rng[15:0];
            adc_sample <= smp;
            words(2);
            chk("link data", {13'h0, 3'b100, smp}, last_word);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        $display("ratio test done");
        hi <= 4'h1;
        lo <= 4'h5;
        apb(1'b1, adc_clk_pkg::IDX_CLK_DIV, 32'h1);
        sync();
        run <= 1'b1;
        duty(h, l);
        duty(h, l);
        chk("div high", 6, h);
        chk("div low", 6, l);
        apb(1'b1, adc_clk_pkg::IDX_CLK_DIV, 32'h0);
        apb(1'b1, adc_clk_pkg::IDX_DCS, 32'h1);
        sync();
        repeat (40) @(posedge pclk);
        duty(h, l);
        chk("dcs high", 3, h);
        chk("dcs low", 3, l);
        apb(1'b1, adc_clk_pkg::IDX_DCS, 32'h0);
        $display("duty test done");
        adc_sample <= 16'h1234;
        power_mode_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("pin down link", 32'h0, link_up);
        apb(1'b0, adc_clk_pkg::IDX_STATUS, 32'h0);
        chk("pin down mode", 32'h2, rd >> 2 & 32'h3);
        power_mode_pin <= 1'b0;
        sync();
        chk("wake link", 32'h1, link_up);
        apb(1'b1, adc_clk_pkg::IDX_PIN_FUNC, 32'h1);
        power_mode_pin <= 1'b1;
        words(2);
        chk("stby link", 32'h1, link_up);
        chk("stby word", 32'h40000, last_word);
        apb(1'b1, adc_clk_pkg::IDX_LINK_CTRL, 32'h80);
        words(2);
        chk("stby k", 32'h7bcbc, last_word);
        power_mode_pin <= 1'b0;
        apb(1'b1, adc_clk_pkg::IDX_SOFT_PD, 32'h1);
        repeat (4) @(posedge pclk);
        chk("soft down", 32'h0, link_up);
        apb(1'b1, adc_clk_pkg::IDX_SOFT_PD, 32'h0);
        repeat (4) @(posedge pclk);
        chk("soft up", 32'h1, link_up);
        $display("power test done");
        print_verdict();
    end
endmodule : testbench
